/* hdl/gpw_if.sv */
// carriers between the port top and its interrupt and wake modules
`timescale 1ns/1ps
`default_nettype none
interface gpw_irq_if;
  logic level;
  logic [gpw_pkg::TRIG_W-1:0] mode;
  logic filt_en;
  logic clear;
  logic pending;
  modport chan (input level, input mode, input filt_en, input clear, output pending);
  modport ctrl (output level, output mode, output filt_en, output clear, input pending);
endinterface

interface gpw_wake_if;
  logic [gpw_pkg::PIN_COUNT-1:0] level;
  logic [gpw_pkg::PIN_COUNT-1:0] enable;
  logic filt_en;
  logic tick;
  logic sleep_enter;
  logic asleep;
  logic wake;
  modport mon (input level, input enable, input filt_en, input tick, input sleep_enter,
    output asleep, output wake);
  modport ctrl (output level, output enable, output filt_en, output tick,
    output sleep_enter, input asleep, input wake);
endinterface
`default_nettype wire

/* hdl/gpw_irq_chan.sv */
// one external interrupt channel: glitch filter, trigger decode, pending flag
`timescale 1ns/1ps
`default_nettype none
module gpw_irq_chan #(
  parameter int FILT_CYCLES = gpw_pkg::IRQ_FILT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // channel
  gpw_irq_if.chan irq
);
  localparam int CNT_W = $clog2(FILT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILT_CYCLES - 1);
  logic [CNT_W-1:0] stable_cnt_ff;
  logic filt_lvl_ff;
  logic prev_ff;
  logic pending_ff;
  logic cur;
  logic set;

  // a new level is taken only after it has held for the whole window
  always_ff @(posedge sys_clk) begin
    if (rst || irq.level == filt_lvl_ff) begin
      stable_cnt_ff <= '0;
      filt_lvl_ff <= rst ? 1'b0 : filt_lvl_ff;
    end else if (stable_cnt_ff == CNT_LAST) begin
      stable_cnt_ff <= '0;
      filt_lvl_ff <= irq.level;
    end else begin
      stable_cnt_ff <= stable_cnt_ff + 1'b1;
    end
  end

  assign cur = irq.filt_en ? filt_lvl_ff : irq.level;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= cur;
    end
  end

  always_comb begin
    case (gpw_pkg::gpw_trig_t'(irq.mode))
      gpw_pkg::trig_rise: set = cur & ~prev_ff;
      gpw_pkg::trig_fall: set = ~cur & prev_ff;
      gpw_pkg::trig_both: set = cur ^ prev_ff;
      gpw_pkg::trig_high: set = cur;
      gpw_pkg::trig_low: set = ~cur;
      default: set = 1'b0;
    endcase
  end

  // set beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending_ff <= 1'b0;
    end else begin
      pending_ff <= set | (pending_ff & ~irq.clear);
    end
  end

  assign irq.pending = pending_ff;
endmodule
`default_nettype wire

/* hdl/gpw_pkg.sv */
// shared constants and types of the gpio port, wake and interrupt block
package gpw_pkg;
  // ==========================================================
  // geometry
  localparam int PORT_COUNT = 3;
  localparam int PINS_PER_PORT = 8;
  localparam int PIN_COUNT = PORT_COUNT * PINS_PER_PORT;
  localparam int CFG_W = 4;
  localparam int IRQ_COUNT = 4;
  localparam int IRQ_SEL_W = 5;
  localparam int TRIG_W = 3;
  // ==========================================================
  // pin roles
  localparam int BOOT_PIN_INDEX = 5;
  localparam int IRQ_FIRST_PIN = 8;
  localparam int IRQ_SECOND_PIN = 14;
  localparam logic [IRQ_SEL_W-1:0] IRQ_SEL_MAX = 5'h17;
  // ==========================================================
  // per-pin configuration codes
  typedef enum logic [CFG_W-1:0] {
    cfg_analog = 4'h0,
    cfg_push_pull = 4'h1,
    cfg_in_float = 4'h4,
    cfg_open_drain = 4'h5,
    cfg_in_pull = 4'h8,
    cfg_alt_push_pull = 4'h9,
    cfg_alt_spi_clk = 4'hB,
    cfg_alt_open_drain = 4'hD
  } gpw_cfg_t;
  // external interrupt trigger codes
  typedef enum logic [TRIG_W-1:0] {
    trig_off = 3'h0,
    trig_rise = 3'h1,
    trig_fall = 3'h2,
    trig_both = 3'h3,
    trig_high = 3'h4,
    trig_low = 3'h5
  } gpw_trig_t;
  // ==========================================================
  // timing
  localparam int CLK_NS = 100;
  localparam int CLK_HZ = 10_000_000;
  localparam int BOOT_DELAY_PERIODS = 512;
  localparam int HFRC_PERIOD_NS = 100;
  localparam int BOOT_DELAY_CYCLES =
    (BOOT_DELAY_PERIODS * HFRC_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_RC_HZ = 10_000;
  localparam int WAKE_TICK_CYCLES = CLK_HZ / WAKE_RC_HZ;
  localparam int IRQ_MIN_NS = 80;
  localparam int IRQ_MIN_FILT_NS = 450;
  localparam int IRQ_FILT_CYCLES = (IRQ_MIN_FILT_NS / CLK_NS < 1) ? 1 : IRQ_MIN_FILT_NS / CLK_NS;
endpackage

/* hdl/gpw_port_top.sv */
// three eight-pin gpio ports with boot strap, wake monitor and external interrupts
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module gpw_port_top #(
  parameter int BOOT_DELAY_CYCLES = gpw_pkg::BOOT_DELAY_CYCLES,
  parameter int WAKE_TICK_CYCLES = gpw_pkg::WAKE_TICK_CYCLES,
  parameter int IRQ_FILT_CYCLES = gpw_pkg::IRQ_FILT_CYCLES
) (
  // clock and reset (pin or power-on reset)
  input wire logic sys_clk,
  input wire logic rst,
  // pins, index = port * 8 + bit
  input wire logic [gpw_pkg::PIN_COUNT-1:0] pin_in,
  output logic [gpw_pkg::PIN_COUNT-1:0] pin_out,
  output logic [gpw_pkg::PIN_COUNT-1:0] pin_oe,
  output logic [gpw_pkg::PIN_COUNT-1:0] pin_pull_up_en,
  output logic [gpw_pkg::PIN_COUNT-1:0] pin_pull_down_en,
  // pin configuration, four bits per pin
  input wire logic [gpw_pkg::PIN_COUNT*gpw_pkg::CFG_W-1:0] port_config_pair,
  // output register writes, one strobe per port
  input wire logic [gpw_pkg::PORT_COUNT-1:0] port_output_wr,
  input wire logic [gpw_pkg::PIN_COUNT-1:0] port_output_wdata,
  input wire logic [gpw_pkg::PORT_COUNT-1:0] port_set_wr,
  input wire logic [gpw_pkg::PIN_COUNT-1:0] port_set_reg,
  input wire logic [gpw_pkg::PORT_COUNT-1:0] port_clear_wr,
  input wire logic [gpw_pkg::PIN_COUNT-1:0] port_clear_reg,
  // register read views
  output logic [gpw_pkg::PIN_COUNT-1:0] port_input_reg,
  output logic [gpw_pkg::PIN_COUNT-1:0] port_output_reg,
  // on-chip peripherals
  input wire logic [gpw_pkg::PIN_COUNT-1:0] alt_out,
  output logic [gpw_pkg::PIN_COUNT-1:0] periph_in,
  // boot strap status
  output logic boot_select_capture,
  output logic boot_done,
  // wake
  input wire logic [gpw_pkg::PIN_COUNT-1:0] port_wake_enable,
  input wire logic wake_filter_enable,
  input wire logic wake_sel_pin_activity,
  input wire logic sleep_enter,
  input wire logic wake_status_clear,
  output logic deep_sleep_active,
  output logic wake_event,
  output logic wake_by_pins,
  // external interrupts
  input wire logic [gpw_pkg::IRQ_COUNT*gpw_pkg::TRIG_W-1:0] irq_trigger_mode,
  input wire logic [gpw_pkg::IRQ_COUNT-1:0] irq_filter_enable,
  input wire logic [gpw_pkg::IRQ_SEL_W-1:0] third_irq_pin_select,
  input wire logic [gpw_pkg::IRQ_SEL_W-1:0] fourth_irq_pin_select,
  input wire logic [gpw_pkg::IRQ_COUNT-1:0] ext_irq_pending_clear,
  output logic [gpw_pkg::IRQ_COUNT-1:0] ext_irq_pending
);
  localparam int N = gpw_pkg::PIN_COUNT;
  localparam int P = gpw_pkg::PINS_PER_PORT;
  localparam int BOOT_CNT_W = $clog2(BOOT_DELAY_CYCLES + 1);
  localparam logic [BOOT_CNT_W-1:0] BOOT_LAST = BOOT_CNT_W'(BOOT_DELAY_CYCLES - 1);
  localparam int TICK_W = $clog2(WAKE_TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(WAKE_TICK_CYCLES - 1);

  // ==========================================================
  // pin drive decode
  typedef struct packed {
    logic drv;
    logic oe;
    logic pu;
    logic pd;
    logic digital;
  } gpw_drive_t;

  function automatic gpw_drive_t pin_drive(input logic [gpw_pkg::CFG_W-1:0] cfg,
                                           input logic out_bit, input logic alt_bit);
    gpw_drive_t d;
    d = '{drv: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0, digital: 1'b1};
    case (gpw_pkg::gpw_cfg_t'(cfg))
      gpw_pkg::cfg_analog: begin
        d.digital = 1'b0;
      end
      gpw_pkg::cfg_in_pull: begin
        d.pu = out_bit;
        d.pd = ~out_bit;
      end
      gpw_pkg::cfg_push_pull: begin
        d.oe = 1'b1;
        d.drv = out_bit;
      end
      gpw_pkg::cfg_open_drain: begin
        d.oe = ~out_bit;
      end
      gpw_pkg::cfg_alt_push_pull, gpw_pkg::cfg_alt_spi_clk: begin
        d.oe = 1'b1;
        d.drv = alt_bit;
      end
      gpw_pkg::cfg_alt_open_drain: begin
        d.oe = ~alt_bit;
      end
      default: begin
        // floating input and undefined codes leave the pin undriven
        d.oe = 1'b0;
      end
    endcase
    return d;
  endfunction

  // ==========================================================
  // pin synchroniser
  logic [N-1:0] pin_meta_ff;
  logic [N-1:0] pin_sync_ff;
  logic [N-1:0] in_path;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ==========================================================
  // boot strap sampling
  logic [BOOT_CNT_W-1:0] boot_cnt_ff;
  logic boot_done_ff;
  logic boot_select_capture_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_cnt_ff <= '0;
      boot_done_ff <= 1'b0;
    end else if (!boot_done_ff) begin
      boot_cnt_ff <= boot_cnt_ff + 1'b1;
      boot_done_ff <= boot_cnt_ff == BOOT_LAST;
    end
  end

  // the level is caught after reset release, never under it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_select_capture_ff <= 1'b0;
    end else if (!boot_done_ff && boot_cnt_ff == BOOT_LAST) begin
      boot_select_capture_ff <= pin_sync_ff[gpw_pkg::BOOT_PIN_INDEX];
    end
  end

  // ==========================================================
  // output register
  logic [N-1:0] out_reg_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_reg_ff <= '0;
    end else begin
      for (int p = 0; p < gpw_pkg::PORT_COUNT; p++) begin
        if (port_output_wr[p]) begin
          out_reg_ff[p*P +: P] <= port_output_wdata[p*P +: P];
        end else begin
          out_reg_ff[p*P +: P] <= (out_reg_ff[p*P +: P]
            | (port_set_wr[p] ? port_set_reg[p*P +: P] : '0))
            & ~(port_clear_wr[p] ? port_clear_reg[p*P +: P] : '0);
        end
      end
    end
  end

  // ==========================================================
  // per-pin drive and input path
  logic [N-1:0] drv_nxt;
  logic [N-1:0] oe_nxt;
  logic [N-1:0] pu_nxt;
  logic [N-1:0] pd_nxt;
  logic [N-1:0] pin_out_ff;
  logic [N-1:0] pin_oe_ff;
  logic [N-1:0] pin_pu_ff;
  logic [N-1:0] pin_pd_ff;
  logic [N-1:0] in_reg_ff;
  logic [N-1:0] periph_in_ff;

  for (genvar i = 0; i < N; i++) begin : g_pin
    gpw_drive_t d;
    assign d = pin_drive(port_config_pair[i*gpw_pkg::CFG_W +: gpw_pkg::CFG_W],
                         out_reg_ff[i], alt_out[i]);
    if (i == gpw_pkg::BOOT_PIN_INDEX) begin : g_strap
      // strap overrides the configuration until sampled
      assign drv_nxt[i] = boot_done_ff & d.drv;
      assign oe_nxt[i] = boot_done_ff & d.oe;
      assign pu_nxt[i] = ~boot_done_ff | d.pu;
      assign pd_nxt[i] = boot_done_ff & d.pd;
    end else begin : g_norm
      assign drv_nxt[i] = d.drv;
      assign oe_nxt[i] = d.oe;
      assign pu_nxt[i] = d.pu;
      assign pd_nxt[i] = d.pd;
    end
    assign in_path[i] = d.digital ? pin_sync_ff[i] : 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      pin_pu_ff <= '0;
      pin_pd_ff <= '0;
      pin_pu_ff[gpw_pkg::BOOT_PIN_INDEX] <= 1'b1;
    end else begin
      pin_out_ff <= drv_nxt;
      pin_oe_ff <= oe_nxt;
      pin_pu_ff <= pu_nxt;
      pin_pd_ff <= pd_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_reg_ff <= '1;
      periph_in_ff <= '1;
    end else begin
      in_reg_ff <= in_path;
      periph_in_ff <= in_path;
    end
  end

  // ==========================================================
  // wake monitor
  logic [TICK_W-1:0] tick_cnt_ff;
  logic wake_tick;
  logic wake_event_ff;
  logic wake_by_pins_ff;
  logic deep_sleep_ff;
  gpw_wake_if wake_bus ();

  // slow rc sample rate derived from the system clock
  always_ff @(posedge sys_clk) begin
    if (rst || tick_cnt_ff == TICK_LAST) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end
  assign wake_tick = tick_cnt_ff == TICK_LAST;

  assign wake_bus.level = in_path; // analog pins read high and never wake
  assign wake_bus.enable = wake_sel_pin_activity ? port_wake_enable : '0;
  assign wake_bus.filt_en = wake_filter_enable;
  assign wake_bus.tick = wake_tick;
  assign wake_bus.sleep_enter = sleep_enter;

  gpw_wake_mon u_wake (
    .sys_clk(sys_clk),
    .rst(rst),
    .w(wake_bus.mon)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_event_ff <= 1'b0;
      wake_by_pins_ff <= 1'b0;
      deep_sleep_ff <= 1'b0;
    end else begin
      wake_event_ff <= wake_bus.wake;
      deep_sleep_ff <= wake_bus.asleep;
      // a wake in the clearing cycle is kept
      wake_by_pins_ff <= wake_bus.wake | (wake_by_pins_ff & ~wake_status_clear);
    end
  end

  // ==========================================================
  // external interrupts
  logic [N-1:0] irq_src_lvl;
  logic [gpw_pkg::IRQ_COUNT-1:0] irq_pending_ff;
  logic [gpw_pkg::IRQ_COUNT-1:0] irq_level;

  // selects above the last pin fall back to pin zero
  function automatic logic pick_pin(input logic [gpw_pkg::IRQ_SEL_W-1:0] sel,
                                    input logic [N-1:0] lvl);
    return (sel > gpw_pkg::IRQ_SEL_MAX) ? lvl[0] : lvl[sel];
  endfunction

  assign irq_src_lvl = in_path;
  assign irq_level[0] = irq_src_lvl[gpw_pkg::IRQ_FIRST_PIN];
  assign irq_level[1] = irq_src_lvl[gpw_pkg::IRQ_SECOND_PIN];
  assign irq_level[2] = pick_pin(third_irq_pin_select, irq_src_lvl);
  assign irq_level[3] = pick_pin(fourth_irq_pin_select, irq_src_lvl);

  for (genvar k = 0; k < gpw_pkg::IRQ_COUNT; k++) begin : g_irq
    gpw_irq_if irq_bus ();
    assign irq_bus.level = irq_level[k];
    assign irq_bus.mode = irq_trigger_mode[k*gpw_pkg::TRIG_W +: gpw_pkg::TRIG_W];
    assign irq_bus.filt_en = irq_filter_enable[k];
    assign irq_bus.clear = ext_irq_pending_clear[k];
    gpw_irq_chan #(
      .FILT_CYCLES(IRQ_FILT_CYCLES)
    ) u_chan (
      .sys_clk(sys_clk),
      .rst(rst),
      .irq(irq_bus.chan)
    );
    assign irq_pending_ff[k] = irq_bus.pending;
  end

  // ==========================================================
  // outputs
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign pin_pull_up_en = pin_pu_ff;
  assign pin_pull_down_en = pin_pd_ff;
  assign port_input_reg = in_reg_ff;
  assign port_output_reg = out_reg_ff;
  assign periph_in = periph_in_ff;
  assign boot_select_capture = boot_select_capture_ff;
  assign boot_done = boot_done_ff;
  assign deep_sleep_active = deep_sleep_ff;
  assign wake_event = wake_event_ff;
  assign wake_by_pins = wake_by_pins_ff;
  assign ext_irq_pending = irq_pending_ff;
endmodule
`default_nettype wire

/* hdl/gpw_wake_mon.sv */
// deep sleep wake monitor with optional three-sample filter
`timescale 1ns/1ps
`default_nettype none
module gpw_wake_mon (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wake channel
  gpw_wake_if.mon w
);
  localparam int N = gpw_pkg::PIN_COUNT;
  localparam logic [1:0] FILL_FULL = 2'h2;
  logic [N-1:0] captured_ff;
  logic [N-1:0] hist1_ff;
  logic [N-1:0] hist2_ff;
  logic [1:0] fill_ff;
  logic asleep_ff;
  logic wake_ff;
  logic raw_hit;
  logic filt_hit;

  assign raw_hit = |((w.level ^ captured_ff) & w.enable);
  assign filt_hit = w.tick && fill_ff == FILL_FULL &&
    |(w.enable & ~(w.level ^ hist1_ff) & ~(hist1_ff ^ hist2_ff) & (w.level ^ captured_ff));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      captured_ff <= '0;
      hist1_ff <= '0;
      hist2_ff <= '0;
      fill_ff <= '0;
    end else if (w.sleep_enter) begin
      captured_ff <= w.level;
      fill_ff <= '0;
    end else if (w.tick) begin
      hist2_ff <= hist1_ff;
      hist1_ff <= w.level;
      fill_ff <= (fill_ff == FILL_FULL) ? fill_ff : fill_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      asleep_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else if (w.sleep_enter) begin
      asleep_ff <= 1'b1;
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= asleep_ff & (w.filt_en ? filt_hit : raw_hit);
      asleep_ff <= asleep_ff & ~(w.filt_en ? filt_hit : raw_hit);
    end
  end

  assign w.asleep = asleep_ff;
  assign w.wake = wake_ff;
endmodule
`default_nettype wire

/* verif/gpw_board_model.sv */
// board model: wire level of every pin from drivers and pulls
`timescale 1ns/1ps
`default_nettype none
module gpw_board_model (
  // clock
  input wire logic sys_clk,
  // device side
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pull_up,
  input wire logic [23:0] pull_down,
  // board drivers
  input wire logic [23:0] ext_drv,
  input wire logic [23:0] ext_en,
  // level seen by the device
  output logic [23:0] pin_in
);
  logic float_ff = 1'h0;
  // an undriven pin wanders, so a stale level never passes for a real one
  always @(posedge sys_clk) begin
    float_ff <= ~float_ff;
  end
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_drv[i];
      end else if (pull_up[i] || pull_down[i]) begin
        pin_in[i] = pull_up[i];
      end else begin
        pin_in[i] = float_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/gpw_port_top_monitor.sv */
// concurrent checks on the gpio port top ports
`timescale 1ns/1ps
`default_nettype none
module gpw_port_top_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins and registers
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_pull_up_en,
  input wire logic [23:0] pin_pull_down_en,
  input wire logic [95:0] port_config_pair,
  input wire logic [2:0] port_output_wr,
  input wire logic [2:0] port_set_wr,
  input wire logic [23:0] port_set_reg,
  input wire logic [2:0] port_clear_wr,
  input wire logic [23:0] port_clear_reg,
  input wire logic [23:0] port_input_reg,
  input wire logic [23:0] port_output_reg,
  input wire logic [23:0] alt_out,
  input wire logic [23:0] periph_in,
  // status
  input wire logic boot_select_capture,
  input wire logic boot_done,
  input wire logic deep_sleep_active,
  input wire logic wake_event,
  input wire logic [11:0] irq_trigger_mode,
  input wire logic [3:0] irq_filter_enable,
  input wire logic [3:0] ext_irq_pending_clear,
  input wire logic [3:0] ext_irq_pending
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // boot strap
  property p_boot_pull; !boot_done |-> pin_pull_up_en[5] && !pin_oe[5]; endproperty
  a_boot_pull: assert property (p_boot_pull) else $error("strap pull lost");
  property p_boot_once; boot_done |=> boot_done && $stable(boot_select_capture); endproperty
  a_boot_once: assert property (p_boot_once) else $error("strap resampled");
  property p_boot_float;
    $past(boot_done) && $past(port_config_pair[23:20]) == 4'h4 |-> !pin_pull_up_en[5];
  endproperty
  a_boot_float: assert property (p_boot_float) else $error("strap pull kept");
  // ==========================================================
  // pin modes
  for (genvar i = 0; i < 24; i++) begin : g_pin
    wire logic [3:0] c = port_config_pair[4*i+3:4*i];
    property p_analog;
      (c == 4'h0 && boot_done) [*4] |-> port_input_reg[i] && !pin_oe[i] && !pin_pull_up_en[i];
    endproperty
    a_analog: assert property (p_analog) else $error("analog pin wrong");
    property p_push;
      $past(boot_done) && $past(c) == 4'h1 |-> pin_oe[i] && pin_out[i] == $past(port_output_reg[i]);
    endproperty
    a_push: assert property (p_push) else $error("push-pull drive wrong");
    property p_open;
      $past(boot_done) && $past(c) == 4'h5 |-> pin_oe[i] == !$past(port_output_reg[i]);
    endproperty
    a_open: assert property (p_open) else $error("open-drain drive wrong");
    property p_alt;
      $past(boot_done) && ($past(c) == 4'h9 || $past(c) == 4'hB) |-> pin_oe[i] && pin_out[i] == $past(alt_out[i]);
    endproperty
    a_alt: assert property (p_alt) else $error("alternate drive wrong");
    property p_pull;
      $past(boot_done) && $past(c) == 4'h8 |-> pin_pull_up_en[i] == $past(port_output_reg[i]) && !pin_oe[i];
    endproperty
    a_pull: assert property (p_pull) else $error("pull choice wrong");
  end
  // ==========================================================
  // output register, interrupts, wake
  property p_set;
    port_set_wr[0] && !port_output_wr[0] && !port_clear_wr[0] |=> port_output_reg[7:0] == ($past(port_output_reg[7:0]) | $past(port_set_reg[7:0]));
  endproperty
  a_set: assert property (p_set) else $error("set write wrong");
  property p_clr;
    port_clear_wr[0] && !port_output_wr[0] |=> port_output_reg[7:0] == (($past(port_output_reg[7:0])
      | ({8{$past(port_set_wr[0])}} & $past(port_set_reg[7:0]))) & ~$past(port_clear_reg[7:0]));
  endproperty
  a_clr: assert property (p_clr) else $error("clear write wrong");
  property p_keep; ext_irq_pending[0] && !ext_irq_pending_clear[0] |=> ext_irq_pending[0]; endproperty
  a_keep: assert property (p_keep) else $error("pending flag dropped");
  property p_lvl;
    (irq_trigger_mode[2:0] == 3'h4 && !irq_filter_enable[0] && periph_in[8]) [*2] |-> ext_irq_pending[0];
  endproperty
  a_lvl: assert property (p_lvl) else $error("level flag not held");
  property p_off;
    $past(irq_trigger_mode[2:0]) == 3'h0 && !$past(ext_irq_pending[0]) |-> !ext_irq_pending[0];
  endproperty
  a_off: assert property (p_off) else $error("disabled irq set");
  property p_wake; wake_event |-> $past(deep_sleep_active) ##1 !wake_event; endproperty
  a_wake: assert property (p_wake) else $error("wake outside sleep");
endmodule
bind gpw_port_top gpw_port_top_monitor gpw_port_top_monitor_inst (.*);
`default_nettype wire

/* verif/gpw_port_top_tb.sv */
// self-checking bench of the gpio port, wake and interrupt block
`timescale 1ns/1ps
`default_nettype none
module gpw_port_top_tb;
  localparam int N = gpw_pkg::PIN_COUNT;
  localparam int BD = 8;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [N-1:0] pin_in, pin_out, pin_oe, pu, pd, drv, den, owd, sreg, creg, alt, wen, in_r, out_r;
  logic [N-1:0] per, m_out, e_oe, e_out, e_pu, e_pd, e_in;
  logic [4*N-1:0] cfg;
  logic [2:0] owr, swr, cwr;
  logic bsc, bdone, wfe, wsel, slp, wclr, dsa, wev, wbp, seen;
  logic [11:0] tm;
  logic [3:0] fe, pclr, pend, cc;
  logic [4:0] sel3, sel4;
  logic [3:0] codes [8] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9, 4'hD, 4'hB};
  int n_mismatch = 0;
  int compares = 0;
  int seed = 33;
  always #50 sys_clk = ~sys_clk;
  gpw_port_top #(.BOOT_DELAY_CYCLES(BD), .WAKE_TICK_CYCLES(4), .IRQ_FILT_CYCLES(4))
    gpw_port_top_inst (.sys_clk, .rst, .pin_in, .pin_out, .pin_oe,
    .pin_pull_up_en(pu), .pin_pull_down_en(pd), .port_config_pair(cfg), .port_output_wr(owr),
    .port_output_wdata(owd), .port_set_wr(swr), .port_set_reg(sreg), .port_clear_wr(cwr),
    .port_clear_reg(creg), .port_input_reg(in_r), .port_output_reg(out_r), .alt_out(alt),
    .periph_in(per), .boot_select_capture(bsc), .boot_done(bdone), .port_wake_enable(wen),
    .wake_filter_enable(wfe), .wake_sel_pin_activity(wsel), .sleep_enter(slp),
    .wake_status_clear(wclr), .deep_sleep_active(dsa), .wake_event(wev), .wake_by_pins(wbp),
    .irq_trigger_mode(tm), .irq_filter_enable(fe), .third_irq_pin_select(sel3),
    .fourth_irq_pin_select(sel4), .ext_irq_pending_clear(pclr), .ext_irq_pending(pend));
  gpw_board_model gpw_board_model_inst (.sys_clk, .pin_out, .pin_oe, .pull_up(pu),
    .pull_down(pd), .ext_drv(drv), .ext_en(den), .pin_in);
  task automatic chk(input string nm, input logic [N-1:0] e, input logic [N-1:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic clr(input logic [3:0] m);
    pclr = m;
    cyc(1);
    pclr = 4'h0;
    cyc(3);
  endtask
  // reset, then bounded wait for strap sampling
  task automatic boot;
    int k;
    k = 0;
    rst = 1'h1;
    cyc(8);
    rst = 1'h0;
    cyc(1);
    chk("strap_pull", 24'h000020, pu);
    while (bdone !== 1'h1 && k < BD + 8) begin
      cyc(1);
      k++;
    end
    if (k == BD + 8) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic pulse(input int k, input int p, input int len, input logic e);
    clr(4'hF);
    drv[p] = 1'h1;
    cyc(len);
    drv[p] = 1'h0;
    cyc(10);
    chk("irq_pulse", N'(e), N'(pend[k]));
  endtask
  function automatic logic f_lvl(input int m, input logic lv);
    return (m == 4 && lv) || (m == 5 && !lv);
  endfunction
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {drv, den, owd, sreg, creg, alt, wen, owr, swr, cwr} = '0;
    {wfe, wsel, slp, wclr, tm, fe, pclr, sel3, sel4} = '0;
    cfg = {N{4'h4}};
    m_out = '0;
    // strap driven low, then left to the pull-up
    for (int b = 0; b < 2; b++) begin
      den[5] = (b == 0);
      boot();
      cyc(2);
      chk("strap_capture", N'(b), N'(bsc));
      chk("strap_float", '0, pu);
    end
    // random writes, back to back on all ports
    for (int t = 0; t < 60; t++) begin
      owr = 3'($random(seed));
      swr = 3'($random(seed));
      cwr = 3'($random(seed));
      owd = N'($random(seed));
      sreg = N'($random(seed));
      creg = N'($random(seed));
      for (int i = 0; i < N; i++) begin
        if (owr[i/8]) m_out[i] = owd[i];
        else if (cwr[i/8] && creg[i]) m_out[i] = 1'h0;
        else if (swr[i/8] && sreg[i]) m_out[i] = 1'h1;
      end
      cyc(1);
      chk("out_reg", m_out, out_r);
    end
    {owr, swr, cwr} = '0;
    // every configuration code on every pin
    den = '1;
    for (int c = 0; c < 8; c++) begin
      cc = codes[c];
      cfg = {N{cc}};
      alt = N'($random(seed));
      drv = N'($random(seed));
      cyc(5);
      for (int i = 0; i < N; i++) begin
        e_oe[i] = cc == 4'h1 || cc == 4'h9 || cc == 4'hB
          || (cc == 4'h5 && !m_out[i]) || (cc == 4'hD && !alt[i]);
        e_out[i] = cc == 4'h1 ? m_out[i] : (cc == 4'h9 || cc == 4'hB) && alt[i];
        e_pu[i] = cc == 4'h8 && m_out[i];
        e_pd[i] = cc == 4'h8 && !m_out[i];
        e_in[i] = cc == 4'h0 || (e_oe[i] ? e_out[i] : drv[i]);
      end
      chk("pin_oe", e_oe, pin_oe);
      chk("pin_out", e_out & e_oe, pin_out & pin_oe);
      chk("pull_up", e_pu, pu);
      chk("pull_down", e_pd, pd);
      chk("input_reg", e_in, in_r);
      chk("periph_in", e_in, per);
    end
    cfg = {N{4'h4}};
    drv = '0;
    // every trigger code on the first interrupt
    for (int m = 0; m < 6; m++) begin
      tm = {9'h000, 3'(m)};
      cyc(8);
      clr(4'h1);
      chk("irq_idle", N'(f_lvl(m, 1'h0)), N'(pend[0]));
      for (int lv = 1; lv >= 0; lv--) begin
        drv[8] = lv[0];
        cyc(8);
        chk("irq_edge", N'(m >= 3 || m == 2 - lv), N'(pend[0]));
        clr(4'h1);
        chk("irq_clear", N'(f_lvl(m, lv[0])), N'(pend[0]));
      end
    end
    tm = 12'h249;
    fe = 4'h2;
    pulse(0, 8, 1, 1'h1);
    pulse(1, 14, 2, 1'h0);
    pulse(1, 14, 6, 1'h1);
    for (int t = 0; t < 4; t++) begin
      sel3 = 5'($unsigned($random(seed)) % 24);
      sel4 = 5'($unsigned($random(seed)) % 24);
      pulse(2, int'(sel3), 1, 1'h1);
      pulse(3, int'(sel4), 1, 1'h1);
    end
    // wake: plain, source deselected, filtered
    for (int w = 0; w < 3; w++) begin
      drv[16] = 1'h0;
      boot();
      wen = 24'h010000;
      wsel = (w != 1);
      wfe = (w == 2);
      slp = 1'h1;
      cyc(1);
      slp = 1'h0;
      cyc(4);
      chk("asleep", N'(1), N'(dsa));
      drv[16] = 1'h1;
      seen = 1'h0;
      repeat (60) begin
        cyc(1);
        if (wev === 1'h1) seen = 1'h1;
      end
      chk("wake_event", N'(wsel), N'(seen));
      chk("wake_by_pins", N'(wsel), N'(wbp));
      chk("sleep_left", N'(!wsel), N'(dsa));
      wclr = 1'h1;
      cyc(1);
      wclr = 1'h0;
      cyc(2);
      chk("wake_cleared", '0, N'(wbp));
    end
    finish_test();
  end
endmodule
`default_nettype wire
